// [uart_line_modem_status.sv]
// Line and modem status slice of one serial channel, AXI4-Lite slave
//
// Contract
// R1 - Framing flag follows head FIFO character
// R2 - Parity flag, bit 2, follows head character
// R3 - Overrun, bit 1, when arrival meets full
// R4 - Overrun character dropped, FIFO kept intact
// R5 - Data ready, bit 0, while data waits
// R6 - Error flags zero when no error
// R7 - Modem register shows present input states
// R8 - Four change bits set on input change
// R9 - Reading modem register clears change bits
// R10 - Bit 7 flags FIFO errors, read clears
// R11 - Carrier-detect change raises modem interrupt
// R12 - Error flags stored with each character
// R13 - Inputs synchronised before edge detection
`timescale 1ns/1ps
module uart_line_modem_status
  import line_modem_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [line_modem_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [line_modem_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_parity_err,
  input wire logic rx_framing_err,
  input wire logic rx_break,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic cd_n,
  output logic irq
);

  import line_modem_pkg::*;

  localparam int CW = $clog2(DEPTH+1);

  // ----------------------------------------------------------------
  // Bus handshake state
  // ----------------------------------------------------------------
  logic awready_r; // Address slot free
  logic wready_r; // Data slot free
  logic bvalid_r; // Write answer pending
  logic [1:0] bresp_r; // Write answer code
  logic arready_r; // Read slot free
  logic rvalid_r; // Read answer pending
  logic [31:0] rdata_r; // Read answer data
  logic [1:0] rresp_r; // Read answer code
  logic [ADDR_W-1:0] waddr_r; // Held write address
  logic [31:0] wdata_r; // Held write data
  logic [3:0] wstrb_r; // Held byte enables

  // ----------------------------------------------------------------
  // Block state
  // ----------------------------------------------------------------
  logic fifo_en_r; // FIFO mode, else single holding register
  logic overrun_r; // Sticky overrun
  logic fifo_err_r; // Sticky error-in-FIFO summary
  logic [3:0] delta_r; // Modem change bits
  logic [3:0] irq_stat_r; // Sticky interrupt causes
  logic [3:0] irq_mask_r; // Interrupt enables
  logic irq_r; // Registered interrupt

  // ----------------------------------------------------------------
  // Derived strobes
  // ----------------------------------------------------------------
  logic rd_hs; // Read address taken this cycle
  logic wr_go; // Both write halves held, commit now
  logic rd_lsr; // Line status read
  logic rd_msr; // Modem status read
  logic rd_rx; // Receive data read
  logic [CW-1:0] cnt; // FIFO occupancy
  logic [10:0] head; // {break, framing, parity, data}
  logic any_err; // Some held character has an error
  logic full; // No room for another character
  logic push; // Character accepted
  logic pop; // Head character consumed
  logic err_in; // Incoming character carries an error
  logic [3:0] mstate; // {cd, ri, dsr, cts}, active high
  logic [3:0] mchg; // Single-cycle change pulses
  logic [7:0] lsr_value; // Assembled line status
  logic [7:0] msr_value; // Assembled modem status
  logic [31:0] rd_mux; // Read data before registering
  logic rd_ok; // Read address maps to a register
  logic [3:0] irq_set; // Interrupt events this cycle
  logic [3:0] irq_w1c; // Software clears this cycle

  // ----------------------------------------------------------------
  // Receive FIFO with per-character error flags
  // ----------------------------------------------------------------
  rx_err_fifo #(.DEPTH(DEPTH), .WIDTH(11)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(push),
    .push_data({rx_break, rx_framing_err, rx_parity_err,
                rx_char_data}), // [R12]
    .pop(pop),
    .head(head),
    .count(cnt),
    .any_err(any_err)
  );

  // ----------------------------------------------------------------
  // Modem input conditioning
  // ----------------------------------------------------------------
  modem_edge #(.N(4)) u_modem (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins_n({cd_n, ri_n, dsr_n, cts_n}), // [R13]
    .state(mstate),
    .changed(mchg)
  );

  // Outside FIFO mode only one character can be held
  assign full = fifo_en_r ? (cnt == CW'(DEPTH)) : (cnt != '0);
  // A character arriving while full is dropped, stored ones stay
  assign push = rx_char_valid && !full; // [R4]
  assign pop = rd_rx && (cnt != '0);
  assign err_in = rx_parity_err || rx_framing_err || rx_break;

  assign rd_hs = arvalid && arready_r;
  assign rd_lsr = rd_hs && (araddr == OFF_LINE_STATUS);
  assign rd_msr = rd_hs && (araddr == OFF_MODEM_STATUS);
  assign rd_rx = rd_hs && (araddr == OFF_RX_DATA);
  assign wr_go = !awready_r && !wready_r && !bvalid_r;

  // ----------------------------------------------------------------
  // Status assembly
  // ----------------------------------------------------------------
  // Per-character flags show the head entry, zero when empty
  always_comb begin
    lsr_value = 8'h00;
    lsr_value[LS_DATA_READY] = (cnt != '0); // [R5]
    lsr_value[LS_OVERRUN] = overrun_r;
    lsr_value[LS_PARITY] = (cnt != '0) && head[8]; // [R2] [R6]
    lsr_value[LS_FRAMING] = (cnt != '0) && head[9]; // [R1] [R6]
    lsr_value[LS_BREAK] = (cnt != '0) && head[10];
    lsr_value[LS_FIFO_ERR] = fifo_err_r;
  end

  assign msr_value = {mstate, delta_r}; // [R7]

  // ----------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------
  // Overrun is sticky until a line status read; a new one wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_r <= 1'b0;
    end else if (rx_char_valid && full) begin
      overrun_r <= 1'b1; // [R3]
    end else if (rd_lsr) begin
      overrun_r <= 1'b0; // [R6]
    end
  end

  // Summary of errors held in the FIFO; read clears, fresh error wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_err_r <= 1'b0;
    end else if (push && err_in) begin
      fifo_err_r <= 1'b1; // [R10]
    end else if (rd_lsr) begin
      fifo_err_r <= 1'b0; // [R10]
    end else if (any_err && !fifo_err_r && $past(rd_lsr)) begin
      // Still errors inside after the read: report them again
      fifo_err_r <= 1'b1; // [R10]
    end
  end

  // ----------------------------------------------------------------
  // Modem change bits
  // ----------------------------------------------------------------
  // Read clears; a change in the same cycle as the read survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delta_r <= 4'h0;
    end else begin
      delta_r <= mchg | (rd_msr ? 4'h0 : delta_r); // [R8] [R9]
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    irq_set = 4'h0;
    irq_set[IRQ_RX_DATA] = push;
    irq_set[IRQ_LINE_ERR] = (rx_char_valid && full) || (push && err_in);
    irq_set[IRQ_MODEM] = |mchg;
    irq_set[IRQ_CD] = mchg[MS_CD_DELTA]; // [R11]
  end

  assign irq_w1c = (wr_go && waddr_r == OFF_IRQ_STATUS && wstrb_r[0])
                   ? wdata_r[3:0] : 4'h0;

  // Write one to clear, but an event in the same cycle stays set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= 4'h0;
    end else begin
      irq_stat_r <= irq_set | (irq_stat_r & ~irq_w1c); // [R11]
    end
  end

  // Level output straight from a flop, one cycle behind the status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Writable control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_en_r <= CTRL_FIFO_EN_RST;
      irq_mask_r <= IRQ_MASK_RST;
    end else if (wr_go && wstrb_r[0]) begin
      if (waddr_r == OFF_CTRL) fifo_en_r <= wdata_r[CTRL_FIFO_EN];
      if (waddr_r == OFF_IRQ_MASK) irq_mask_r <= wdata_r[3:0];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are taken independently; the answer waits
  // for both, so only one write is ever in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      waddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (awvalid && awready_r) begin
        awready_r <= 1'b0;
        waddr_r <= awaddr;
      end
      if (wvalid && wready_r) begin
        wready_r <= 1'b0;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        // Read-only registers accept and ignore; holes get an error
        bresp_r <= (waddr_r[1:0] == 2'b00 && waddr_r <= OFF_IRQ_MASK)
                   ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (araddr)
      OFF_RX_DATA: rd_mux[7:0] = head[7:0];
      OFF_LINE_STATUS: rd_mux[7:0] = lsr_value;
      OFF_MODEM_STATUS: rd_mux[7:0] = msr_value;
      OFF_CTRL: rd_mux[CTRL_FIFO_EN] = fifo_en_r;
      OFF_IRQ_STATUS: rd_mux[3:0] = irq_stat_r;
      OFF_IRQ_MASK: rd_mux[3:0] = irq_mask_r;
      default: rd_ok = 1'b0;
    endcase
  end

  // Data is captured at the address edge, so read side effects and
  // the value returned always belong to the same instant
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (rd_hs) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign irq = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_fe_head;
    (push && rx_framing_err && cnt == '0) |=> lsr_value[LS_FRAMING];
  endproperty
  a_fe_head: assert property (p_fe_head) // [R1]
    else $error("framing flag missing for head character");

  property p_pe_head;
    (push && rx_parity_err && cnt == '0 && !pop)
      |=> lsr_value[LS_PARITY] ##1 (lsr_value[LS_PARITY] || $past(pop));
  endproperty
  a_pe_head: assert property (p_pe_head) // [R2]
    else $error("parity flag missing for head character");

  property p_overrun;
    (rx_char_valid && full) |=> overrun_r;
  endproperty
  a_overrun: assert property (p_overrun) // [R3]
    else $error("overrun not flagged on full arrival");

  property p_no_push_full;
    (rx_char_valid && full && !pop) |=> (cnt == $past(cnt));
  endproperty
  a_no_push_full: assert property (p_no_push_full) // [R4]
    else $error("FIFO changed on overrun");

  property p_ready;
    (push && cnt == '0) |=> lsr_value[LS_DATA_READY];
  endproperty
  a_ready: assert property (p_ready) // [R5]
    else $error("data ready not raised after first character");

  property p_clean;
    (cnt == '0 && !overrun_r) |-> (lsr_value[3:1] == 3'b000);
  endproperty
  a_clean: assert property (p_clean) // [R6]
    else $error("error flag set with nothing wrong");

  property p_state;
    ##3 (msr_value[7:4] == ~$past({cd_n, ri_n, dsr_n, cts_n}, 2));
  endproperty
  a_state: assert property (p_state) // [R7]
    else $error("modem state does not follow the pins");

  property p_delta_set;
    (mchg != 4'h0) |=> ((delta_r & $past(mchg)) == $past(mchg));
  endproperty
  a_delta_set: assert property (p_delta_set) // [R8]
    else $error("change bit not set on input change");

  property p_delta_clr;
    (rd_msr && mchg == 4'h0) |=> (delta_r == 4'h0);
  endproperty
  a_delta_clr: assert property (p_delta_clr) // [R9]
    else $error("change bits survived a modem status read");

  property p_fifo_err;
    (push && err_in) |=> fifo_err_r;
  endproperty
  a_fifo_err: assert property (p_fifo_err) // [R10]
    else $error("FIFO error summary not raised");

  property p_cd_irq;
    mchg[MS_CD_DELTA] |=> irq_stat_r[IRQ_CD]
      ##1 (irq == irq_mask_r[IRQ_CD] || irq_mask_r != $past(irq_mask_r)
           || irq);
  endproperty
  a_cd_irq: assert property (p_cd_irq) // [R11]
    else $error("carrier change did not raise its interrupt");

  property p_single;
    mchg[0] |=> !mchg[0];
  endproperty
  a_single: assert property (p_single) // [R13]
    else $error("one transition produced two change pulses");

  c_overrun: cover property (rx_char_valid && full);
  c_msr_clear: cover property (rd_msr && delta_r != 4'h0);
  c_irq: cover property ($rose(irq));
  c_fifo_full: cover property (fifo_en_r && cnt == CW'(DEPTH));

endmodule : uart_line_modem_status

// [line_modem_pkg.sv]
// Register map, field positions and reset values of the status slice
package line_modem_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_RX_DATA = 8'h00;
  localparam logic [7:0] OFF_LINE_STATUS = 8'h04;
  localparam logic [7:0] OFF_MODEM_STATUS = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // Line status fields
  // ----------------------------------------------------------------
  localparam int LS_DATA_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY = 2;
  localparam int LS_FRAMING = 3;
  localparam int LS_BREAK = 4;
  localparam int LS_FIFO_ERR = 7;

  // ----------------------------------------------------------------
  // Modem status fields: state nibble above, change nibble below
  // ----------------------------------------------------------------
  localparam int MS_DELTA_LSB = 0;
  localparam int MS_STATE_LSB = 4;
  localparam int MS_CD_DELTA = 3;

  // ----------------------------------------------------------------
  // Control, interrupt fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_FIFO_EN = 0;
  localparam int IRQ_RX_DATA = 0;
  localparam int IRQ_LINE_ERR = 1;
  localparam int IRQ_MODEM = 2;
  localparam int IRQ_CD = 3;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  localparam logic CTRL_FIFO_EN_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : line_modem_pkg

// [rx_err_fifo.sv]
// Receive FIFO that carries error flags beside each character
`timescale 1ns/1ps
module rx_err_fifo #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 11
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic [$clog2(DEPTH+1)-1:0] count,
  output logic any_err
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH]; // Storage, error bits on top
  logic [AW-1:0] wr_ptr_r; // Next slot to fill
  logic [AW-1:0] rd_ptr_r; // Head slot
  logic [CW-1:0] count_r; // Entries held
  logic [DEPTH-1:0] err_vec; // Per-slot live error

  // Storage is not reset; error flags look at occupied slots only, but head shows the slot at rd_ptr_r even when empty
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr_r] <= push_data;
    end
  end

  // Pointers and occupancy; caller never pushes when full
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
      if (pop) rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
      if (push && !pop) count_r <= CW'(count_r + 1'b1);
      else if (pop && !push) count_r <= CW'(count_r - 1'b1);
    end
  end

  // A slot counts only while it lies between head and tail
  for (genvar g = 0; g < DEPTH; g++) begin : g_err
    logic [AW-1:0] off;
    assign off = AW'(AW'(g) - rd_ptr_r);
    assign err_vec[g] = (CW'(off) < count_r)
                        && (|mem[g][WIDTH-1:WIDTH-3]);
  end

  assign head = mem[rd_ptr_r];
  assign count = count_r;
  assign any_err = |err_vec;

endmodule : rx_err_fifo

// [modem_edge.sv]
// Synchroniser and change detector for the modem control inputs
`timescale 1ns/1ps
module modem_edge #(
  parameter int N = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] pins_n,
  output logic [N-1:0] state,
  output logic [N-1:0] changed
);

  logic [N-1:0] meta_r; // First stage, read only by sync_r
  logic [N-1:0] sync_r; // Second stage, safe to use
  logic [N-1:0] prev_r; // Last settled value

  // Three flops per input; reset value is the idle (high) pin level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end else begin
      meta_r <= pins_n;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Pins are active low; status shows the active-high sense
  assign state = ~sync_r;
  // One pulse per synchronised transition; a bouncing pin gives one pulse per bounce
  assign changed = sync_r ^ prev_r;

endmodule : modem_edge

// [host_model.sv]
// AXI4-Lite host model that reads and writes the status slice
`timescale 1ns/1ps
module host_model (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // ----------------------------------------------------------------
  // Idle bus from time zero
  // ----------------------------------------------------------------
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // A wait that never ends is reported and closes the run
  task automatic hang;
    tb.failures++;
    $display("[FAIL] bus answer expected 1 seen 0");
    tb.complete_run();
  endtask : hang

  // ----------------------------------------------------------------
  // Read: address held until taken, rready held until rvalid
  // ----------------------------------------------------------------
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 64);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 64);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 64) begin
      hang();
    end
  endtask : rd

  // ----------------------------------------------------------------
  // Write: address and data offered together, each dropped once taken
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    int n;
    logic ad;
    logic wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      // Channels may be taken in either order
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ad && wd) && n < 64);
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 64);
    r = bresp;
    bready <= 1'b0;
    if (n >= 64) begin
      hang();
    end
  endtask : wr
endmodule : host_model

// [tb.sv]
// Self-checking testbench of the line and modem status slice
`timescale 1ns/1ps
module tb;
  import line_modem_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic rxv = 1'b0; // Character strobe
  logic [7:0] rxd = 8'h00;
  logic [2:0] rxe = 3'h0; // Break, framing, parity
  logic [3:0] pin_n = 4'hf; // cd, ri, dsr, cts; idle high
  int failures = 0;
  int cmp_count = 0;

  always #4 aclk = ~aclk;

  host_model i_host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);

  // Small depth so that a full FIFO is reached quickly
  uart_line_modem_status #(.DEPTH(4)) i_uart_line_modem_status (.aclk,
    .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .rx_char_valid(rxv),
    .rx_char_data(rxd), .rx_parity_err(rxe[0]), .rx_framing_err(rxe[1]),
    .rx_break(rxe[2]), .cts_n(pin_n[0]), .dsr_n(pin_n[1]),
    .ri_n(pin_n[2]), .cd_n(pin_n[3]), .irq);

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string s);
    i_host.rd(a, d, r);
    chk(s, e, d);
  endtask : rdc

  // One-cycle character strobe; a gap cycle follows each call
  task automatic push(input logic [7:0] c, input logic [2:0] e);
    @(posedge aclk);
    rxv <= 1'b1;
    rxd <= c;
    rxe <= e;
    @(posedge aclk);
    rxv <= 1'b0;
  endtask : push

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdc(OFF_LINE_STATUS, 32'h0, "line status");
    rdc(OFF_MODEM_STATUS, 32'h0, "modem status");
    rdc(OFF_CTRL, 32'h0, "ctrl");
    rdc(OFF_IRQ_MASK, 32'h0, "irq mask");
    i_host.rd(8'h18, d, r);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    i_host.wr(8'h18, 32'h0, r);
    chk("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("reset test done");
  endtask : t_reset

  task automatic t_ready;
    push(8'h5a, 3'h0);
    rdc(OFF_LINE_STATUS, 32'h1, "ready set");
    rdc(OFF_RX_DATA, 32'h5a, "holding data");
    rdc(OFF_LINE_STATUS, 32'h0, "ready clear");
    $display("ready test done");
  endtask : t_ready

  // Error flags must follow the head entry as it is popped
  task automatic t_errors;
    i_host.wr(OFF_CTRL, 32'h1, r);
    chk("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
    push(8'h11, 3'b001);
    push(8'h22, 3'b010);
    push(8'h33, 3'b000);
    rdc(OFF_LINE_STATUS, 32'h85, "parity head");
    rdc(OFF_RX_DATA, 32'h11, "pop one");
    rdc(OFF_LINE_STATUS, 32'h89, "framing head");
    rdc(OFF_RX_DATA, 32'h22, "pop two");
    // Summary stays set until read, though the error entry is gone
    rdc(OFF_LINE_STATUS, 32'h81, "stale summary");
    rdc(OFF_LINE_STATUS, 32'h01, "clean head");
    rdc(OFF_RX_DATA, 32'h33, "pop three");
    $display("error test done");
  endtask : t_errors

  // One character more than the FIFO holds
  task automatic t_overrun;
    for (int i = 0; i < 5; i++) begin
      push(8'h40 + 8'(i), 3'h0);
    end
    rdc(OFF_LINE_STATUS, 32'h03, "overrun");
    for (int i = 0; i < 4; i++) begin
      rdc(OFF_RX_DATA, 32'h40 + i, "kept entry");
    end
    rdc(OFF_LINE_STATUS, 32'h0, "after drain");
    $display("overrun test done");
  endtask : t_overrun

  // Each pin falls and rises; the host read acknowledges changes
  task automatic t_modem;
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      pin_n[i] <= 1'b0;
      repeat (5) @(posedge aclk);
      rdc(OFF_MODEM_STATUS, 32'h11 << i, "pin low");
      @(posedge aclk);
      pin_n[i] <= 1'b1;
      repeat (5) @(posedge aclk);
      rdc(OFF_MODEM_STATUS, 32'h1 << i, "pin high");
      rdc(OFF_MODEM_STATUS, 32'h0, "change cleared");
    end
    $display("modem test done");
  endtask : t_modem

  // Carrier change raises irq; mask and write-one-clear drop it
  task automatic t_irq;
    i_host.wr(OFF_IRQ_STATUS, 32'hf, r);
    i_host.wr(OFF_IRQ_MASK, 32'h8, r);
    repeat (2) @(posedge aclk);
    chk("irq idle", 32'h0, {31'h0, irq});
    pin_n[3] <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("irq cd", 32'h1, {31'h0, irq});
    i_host.wr(OFF_IRQ_MASK, 32'h0, r);
    repeat (2) @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    i_host.wr(OFF_IRQ_MASK, 32'h8, r);
    repeat (2) @(posedge aclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    i_host.wr(OFF_IRQ_STATUS, 32'h8, r);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc(OFF_IRQ_STATUS, 32'h4, "irq status modem only");
    rdc(OFF_MODEM_STATUS, 32'h88, "cd change");
    $display("irq test done");
  endtask : t_irq

  // ----------------------------------------------------------------
  // Verdict, reached from the main sequence or a hung wait
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_ready();
    t_errors();
    t_overrun();
    t_modem();
    t_irq();
    complete_run();
  end
endmodule : tb
